//--- rtl/udfc_ctrl.sv
// udfc_ctrl: divisor latch, interrupt enables, fifo control and identification readback.
// assumes register port strobes, clock ticks and pending levels are synchronous to clk.
`timescale 1ns/1ns
module udfc_ctrl
    import udfc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic external_clock_choice,
    input wire logic slow_internal_clock,
    input wire logic fast_internal_clock,
    input wire logic external_clock_tick,
    input wire logic line_error_pend,
    input wire logic rx_data_pend,
    input wire logic rx_timeout_pend,
    input wire logic tx_empty_pend,
    input wire logic [3:0] modem_status,
    input wire logic modem_status_read,
    output logic baud16_tick,
    output logic serial_irq,
    output logic queues_on,
    output logic [3:0] rx_threshold,
    output logic tx_queue_flush,
    output logic rx_queue_flush,
    output logic divisor_latch_access
);

////////////////////////////////////////////////////////////////////////////////
// reset release

    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// register state

    logic [7:0] div_low_ff;
    logic [7:0] div_high_ff;
    logic [3:0] ier_ff;
    logic [7:0] lcr_ff;
    logic queues_on_ff;
    logic [1:0] rx_level_ff;
    logic tx_flush_ff;
    logic rx_flush_ff;
    logic [3:0] modem_prev_ff;
    logic modem_pend_ff;
    logic irq_ff;
    logic [7:0] rdata_ff;
    logic [3:0] threshold_ff;

////////////////////////////////////////////////////////////////////////////////
// address decode

    logic latch_sel;
    logic wr_div_low;
    logic wr_div_high;
    logic wr_ier;
    logic wr_fcr;
    logic wr_lcr;
    logic fcr_keep_on;

    assign latch_sel = lcr_ff[LCR_LATCH_BIT];
    assign wr_div_low = reg_wr && reg_addr == OFS_DATA_DIV_LOW && latch_sel;
    assign wr_div_high = reg_wr && reg_addr == OFS_IER_DIV_HIGH && latch_sel;
    assign wr_ier = reg_wr && reg_addr == OFS_IER_DIV_HIGH && !latch_sel;
    assign wr_fcr = reg_wr && reg_addr == OFS_FCR_IIR;
    assign wr_lcr = reg_wr && reg_addr == OFS_LINE_CTRL;
    // other fcr bits only land when the same write keeps the queues enabled
    assign fcr_keep_on = reg_wdata[FCR_QUEUES_ON_BIT];

////////////////////////////////////////////////////////////////////////////////
// fifo control decode

    logic nxt_queues_on;
    logic queues_falling;
    logic nxt_tx_flush;
    logic nxt_rx_flush;
    logic [1:0] nxt_rx_level;
    logic [3:0] nxt_threshold;

    assign nxt_queues_on = wr_fcr ? reg_wdata[FCR_QUEUES_ON_BIT] : queues_on_ff;
    assign queues_falling = queues_on_ff && !nxt_queues_on;
    // bit 3 is never looked at: no dma request pins exist
    assign nxt_tx_flush = (wr_fcr && fcr_keep_on && reg_wdata[FCR_TX_FLUSH_BIT])
        || queues_falling;
    assign nxt_rx_flush = (wr_fcr && fcr_keep_on && reg_wdata[FCR_RX_FLUSH_BIT])
        || queues_falling;
    assign nxt_rx_level = (wr_fcr && fcr_keep_on) ?
        reg_wdata[FCR_LEVEL_LO_BIT+1:FCR_LEVEL_LO_BIT] : rx_level_ff;

    always_comb begin
        unique case (nxt_rx_level)
            2'h0: nxt_threshold = LEVEL_BYTES_0;
            2'h1: nxt_threshold = LEVEL_BYTES_1;
            2'h2: nxt_threshold = LEVEL_BYTES_2;
            2'h3: nxt_threshold = LEVEL_BYTES_3;
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// interrupt sources and identification

    logic modem_change;
    logic nxt_modem_pend;
    logic en_line;
    logic en_rx;
    logic en_tout;
    logic en_tx;
    logic en_modem;
    logic any_enabled;
    logic [3:0] int_id;
    logic nxt_irq;

    assign modem_change = modem_status != modem_prev_ff;
    // a change in the same cycle as the status read keeps the pending flag
    assign nxt_modem_pend = modem_change || (modem_pend_ff && !modem_status_read);

    assign en_line = ier_ff[IER_LINE_ERR_BIT] && line_error_pend;
    assign en_rx = ier_ff[IER_RX_AVAIL_BIT] && rx_data_pend;
    assign en_tout = ier_ff[IER_RX_AVAIL_BIT] && queues_on_ff && rx_timeout_pend;
    assign en_tx = ier_ff[IER_TX_EMPTY_BIT] && tx_empty_pend;
    assign en_modem = ier_ff[IER_MODEM_BIT] && modem_pend_ff;
    assign any_enabled = en_line || en_rx || en_tout || en_tx || en_modem;

    // identification is inhibited whenever nothing enabled is pending
    assign int_id = en_line ? ID_LINE_ERR :
        en_rx ? ID_RX_AVAIL :
        en_tout ? ID_TIMEOUT :
        en_tx ? ID_TX_EMPTY :
        en_modem ? ID_MODEM : ID_NONE;
    assign nxt_irq = any_enabled;

////////////////////////////////////////////////////////////////////////////////
// read mux

    logic [7:0] iir_value;
    logic [7:0] read_value;

    assign iir_value = {queues_on_ff, queues_on_ff, 2'h0, int_id};
    assign read_value =
        (reg_addr == OFS_DATA_DIV_LOW && latch_sel) ? div_low_ff :
        (reg_addr == OFS_IER_DIV_HIGH && latch_sel) ? div_high_ff :
        (reg_addr == OFS_IER_DIV_HIGH) ? {4'h0, ier_ff} :
        (reg_addr == OFS_FCR_IIR) ? iir_value :
        (reg_addr == OFS_LINE_CTRL) ? lcr_ff : READ_EMPTY;

////////////////////////////////////////////////////////////////////////////////
// registers

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            div_low_ff <= DIV_LOW_RESET;
            div_high_ff <= DIV_HIGH_RESET;
            ier_ff <= IER_RESET;
            lcr_ff <= LCR_RESET;
        end else begin
            if (wr_div_low) begin
                div_low_ff <= reg_wdata;
            end
            if (wr_div_high) begin
                div_high_ff <= reg_wdata;
            end
            if (wr_ier) begin
                ier_ff <= reg_wdata[3:0];
            end
            if (wr_lcr) begin
                lcr_ff <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            queues_on_ff <= 1'b0;
            rx_level_ff <= LEVEL_RESET;
            threshold_ff <= LEVEL_BYTES_0;
            tx_flush_ff <= 1'b0;
            rx_flush_ff <= 1'b0;
        end else begin
            queues_on_ff <= nxt_queues_on;
            rx_level_ff <= nxt_rx_level;
            threshold_ff <= nxt_threshold;
            tx_flush_ff <= nxt_tx_flush;
            rx_flush_ff <= nxt_rx_flush;
        end
    end

    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            modem_prev_ff <= 4'h0;
            modem_pend_ff <= 1'b0;
            irq_ff <= 1'b0;
            rdata_ff <= READ_EMPTY;
        end else begin
            modem_prev_ff <= modem_status;
            modem_pend_ff <= nxt_modem_pend;
            irq_ff <= nxt_irq;
            if (reg_rd) begin
                rdata_ff <= read_value;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// baud clock selection and divider

    logic internal_tick;
    logic chosen_tick;
    logic [14:0] divisor;

    assign internal_tick = div_high_ff[DIVH_CLK_SEL_BIT] ?
        fast_internal_clock : slow_internal_clock;
    // the select bit is simply not consulted on the external path
    assign chosen_tick = external_clock_choice ?
        external_clock_tick : internal_tick;
    assign divisor = {div_high_ff[6:0], div_low_ff};

    udfc_baud_div u_baud_div (
        .clk(clk),
        .rst_n(rst_n_ff),
        .tick_in(chosen_tick),
        .divisor(divisor),
        .baud16_out(baud16_tick)
    );

////////////////////////////////////////////////////////////////////////////////
// outputs

    assign reg_rdata = rdata_ff;
    assign serial_irq = irq_ff;
    assign queues_on = queues_on_ff;
    assign rx_threshold = threshold_ff;
    assign tx_queue_flush = tx_flush_ff;
    assign rx_queue_flush = rx_flush_ff;
    assign divisor_latch_access = lcr_ff[LCR_LATCH_BIT];

////////////////////////////////////////////////////////////////////////////////
// checks

    a_div_low_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_DATA_DIV_LOW && lcr_ff[LCR_LATCH_BIT])
        |=> div_low_ff == $past(reg_wdata))
        else $error("divisor low byte not written");

    a_div_high_read: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_IER_DIV_HIGH && lcr_ff[LCR_LATCH_BIT])
        ##1 !reg_wr
        ##1 (reg_rd && reg_addr == OFS_IER_DIV_HIGH && lcr_ff[LCR_LATCH_BIT] && !reg_wr)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("divisor high byte readback wrong");

    a_ier_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_rd && reg_addr == OFS_IER_DIV_HIGH && !lcr_ff[LCR_LATCH_BIT])
        |=> reg_rdata[7:4] == 4'h0)
        else $error("enable register reserved bits not zero");

    a_irq_all_masked: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (ier_ff == 4'h0) [*2] |-> !serial_irq)
        else $error("interrupt raised with all enables clear");

    a_rx_avail_irq: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (rx_data_pend && ier_ff[IER_RX_AVAIL_BIT]) |=> serial_irq)
        else $error("data available interrupt not raised");

    a_tx_flush_pulse: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR && reg_wdata[0] && reg_wdata[2])
        |=> tx_queue_flush ##1 (!tx_queue_flush || $past(reg_wr)))
        else $error("transmit flush not a single pulse");

    a_rx_flush_pulse: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR && reg_wdata[FCR_QUEUES_ON_BIT]
            && reg_wdata[FCR_RX_FLUSH_BIT])
        |=> rx_queue_flush ##1 (!rx_queue_flush || $past(reg_wr)))
        else $error("receive flush not a single pulse");

    // flush pulses only ever follow a fifo control write
    a_flush_source: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !reg_wr |=> (!tx_queue_flush && !rx_queue_flush))
        else $error("flush pulse without a write");

    a_queues_on_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR)
        |=> queues_on == $past(reg_wdata[FCR_QUEUES_ON_BIT]))
        else $error("queue enable not taken from bit 0");

    a_fcr_gated: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR && !reg_wdata[FCR_QUEUES_ON_BIT])
        |=> rx_threshold == $past(rx_threshold))
        else $error("trigger level changed by a disabling write");

    a_ier_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_IER_DIV_HIGH && !lcr_ff[LCR_LATCH_BIT])
        |=> ier_ff == $past(reg_wdata[3:0]))
        else $error("interrupt enables not written");

    a_div_high_write: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_IER_DIV_HIGH && lcr_ff[LCR_LATCH_BIT])
        |=> div_high_ff == $past(reg_wdata))
        else $error("divisor high byte not written");

    a_line_err_irq: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (line_error_pend && ier_ff[IER_LINE_ERR_BIT]) |=> serial_irq)
        else $error("line error interrupt not raised");

    a_tx_empty_irq: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (tx_empty_pend && ier_ff[IER_TX_EMPTY_BIT]) |=> serial_irq)
        else $error("transmit empty interrupt not raised");

    // a change shows on the interrupt two edges later, via the sticky flag
    a_modem_irq: assert property (@(posedge clk) disable iff (!rst_n_ff)
        ((modem_status != modem_prev_ff) && ier_ff[IER_MODEM_BIT])
        ##1 ier_ff[IER_MODEM_BIT] |=> serial_irq)
        else $error("modem change interrupt not raised");

    a_line_err_first: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_rd && reg_addr == OFS_FCR_IIR && line_error_pend && ier_ff[IER_LINE_ERR_BIT])
        |=> reg_rdata[3:0] == ID_LINE_ERR)
        else $error("line error not identified first");

    a_timeout_id: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_rd && reg_addr == OFS_FCR_IIR && queues_on_ff && rx_timeout_pend
            && ier_ff[IER_RX_AVAIL_BIT] && !line_error_pend && !rx_data_pend)
        |=> reg_rdata == {2'h3, 2'h0, ID_TIMEOUT})
        else $error("character timeout not identified");

    a_mode_exit_flush: assert property (@(posedge clk) disable iff (!rst_n_ff)
        $fell(queues_on) |-> (tx_queue_flush && rx_queue_flush))
        else $error("leaving queue mode did not flush both queues");

    a_level_code: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR && reg_wdata[0] && reg_wdata[7:6] == 2'h3)
        |=> rx_threshold == 4'hE)
        else $error("trigger level fourteen not selected");

    a_dma_bit_inert: assert property (@(posedge clk) disable iff (!rst_n_ff)
        (reg_wr && reg_addr == OFS_FCR_IIR && reg_wdata[3] && !reg_wdata[0] && !queues_on)
        |=> !queues_on && !tx_queue_flush && !rx_queue_flush)
        else $error("dma bit changed operation");
endmodule

//--- rtl/udfc_pkg.sv
// udfc_pkg: offsets, field positions, reset values and codes for the uart control slice.
// assumes a byte-wide register port with a three-bit offset.
package udfc_pkg;
    localparam logic [2:0] OFS_DATA_DIV_LOW = 3'h0;
    localparam logic [2:0] OFS_IER_DIV_HIGH = 3'h1;
    localparam logic [2:0] OFS_FCR_IIR = 3'h2;
    localparam logic [2:0] OFS_LINE_CTRL = 3'h3;

    localparam int LCR_LATCH_BIT = 7;
    localparam int DIVH_CLK_SEL_BIT = 7;
    localparam int IER_RX_AVAIL_BIT = 0;
    localparam int IER_TX_EMPTY_BIT = 1;
    localparam int IER_LINE_ERR_BIT = 2;
    localparam int IER_MODEM_BIT = 3;
    localparam int FCR_QUEUES_ON_BIT = 0;
    localparam int FCR_RX_FLUSH_BIT = 1;
    localparam int FCR_TX_FLUSH_BIT = 2;
    localparam int FCR_LEVEL_LO_BIT = 6;

    localparam logic [7:0] DIV_LOW_RESET = 8'h00;
    localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
    localparam logic [3:0] IER_RESET = 4'h0;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [1:0] LEVEL_RESET = 2'h0;

    localparam logic [3:0] LEVEL_BYTES_0 = 4'h1;
    localparam logic [3:0] LEVEL_BYTES_1 = 4'h4;
    localparam logic [3:0] LEVEL_BYTES_2 = 4'h8;
    localparam logic [3:0] LEVEL_BYTES_3 = 4'hE;

    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_LINE_ERR = 4'h6;
    localparam logic [3:0] ID_RX_AVAIL = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_TX_EMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;

    localparam logic [7:0] READ_EMPTY = 8'h00;
    localparam logic [14:0] DIV_ZERO = 15'h0000;
    localparam logic [14:0] DIV_ONE = 15'h0001;
endpackage

//--- rtl/udfc_baud_div.sv
// udfc_baud_div: divides a selected baud clock tick stream by a fifteen-bit divisor.
// assumes tick_in is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ns
module udfc_baud_div
    import udfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick_in,
    input wire logic [14:0] divisor,
    output logic baud16_out
);
    logic [14:0] count_ff;
    logic baud_ff;
    logic wrap;
    logic [14:0] nxt_count;

    // a zero divisor never wraps, so no pulse comes out (the count still steps on each tick), rather than running at tick rate
    assign wrap = tick_in && (divisor != DIV_ZERO) && (count_ff >= divisor - DIV_ONE);
    assign nxt_count = wrap ? DIV_ZERO : (tick_in ? count_ff + DIV_ONE : count_ff);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= DIV_ZERO;
            baud_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            baud_ff <= wrap;
        end
    end

    assign baud16_out = baud_ff;

    a_div_period: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_in && divisor == DIV_ONE) |=> baud16_out)
        else $error("divide by one missed a tick");
endmodule

//--- test/udfc_far_model.sv
// udfc_far_model: far-side stand-in giving baud clock ticks and modem line changes.
// assumes it shares clk with the slice; every tick is a one-cycle pulse.
`timescale 1ns/1ns
module udfc_far_model #(
    parameter int SLOW_P = 5,
    parameter int FAST_P = 2,
    parameter int EXT_P = 3
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] modem_flip,
    output logic slow_tick,
    output logic fast_tick,
    output logic ext_tick,
    output logic [3:0] modem_lines
);
    logic [7:0] cnt_ff;
    // wrap at a common multiple so every tick stream stays regular
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 8'h00;
            modem_lines <= 4'h0;
        end else begin
            cnt_ff <= (cnt_ff == 8'h3B) ? 8'h00 : cnt_ff + 8'h01;
            modem_lines <= modem_lines ^ modem_flip;
        end
    end
    assign slow_tick = (int'(cnt_ff) % SLOW_P) == 0;
    assign fast_tick = (int'(cnt_ff) % FAST_P) == 0;
    assign ext_tick = (int'(cnt_ff) % EXT_P) == 0;
endmodule

//--- test/udfc_ctrl_tb_top.sv
// udfc_ctrl_tb_top: self-checking bench for the uart control slice.
// assumes the far model supplies ticks and modem lines; pending levels come from here.
`timescale 1ns/1ns
`define CHK(nm, e, g) comparisons++; if ((g) !== (e)) begin \
    $display("[FAIL] %s exp %h got %h", nm, e, g); fail_count++; end
module udfc_ctrl_tb_top;
    import udfc_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, ext_choice, slow, fast, ext;
    logic line_err, rx_data, rx_to, tx_empty, modem_read;
    logic baud16, irq, queues_on, txf, rxf, dla;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [3:0] modem_status, modem_flip, rx_threshold;
    logic [3:0] ids [4];
    logic [31:0] r;
    int fail_count, comparisons, i, cnt, per, exp_n, dv;
    udfc_far_model far (.clk(clk), .reset_n(reset_n), .modem_flip(modem_flip),
        .slow_tick(slow), .fast_tick(fast), .ext_tick(ext), .modem_lines(modem_status));
    udfc_ctrl uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .external_clock_choice(ext_choice), .slow_internal_clock(slow),
        .fast_internal_clock(fast), .external_clock_tick(ext), .line_error_pend(line_err),
        .rx_data_pend(rx_data), .rx_timeout_pend(rx_to), .tx_empty_pend(tx_empty),
        .modem_status(modem_status), .modem_status_read(modem_read), .baud16_tick(baud16),
        .serial_irq(irq), .queues_on(queues_on), .rx_threshold(rx_threshold),
        .tx_queue_flush(txf), .rx_queue_flush(rxf), .divisor_latch_access(dla));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] lvl(input logic [1:0] c);
        return (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h4 : (c == 2'h2) ? 4'h8 : 4'hE;
    endfunction
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    // strobe for exactly the taking edge, then settle so results are visible
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        {reset_n, reg_wr, reg_rd, ext_choice, line_err, rx_data, rx_to, tx_empty} = '0;
        {modem_read, reg_addr, reg_wdata, modem_flip} = '0;
        r = 32'h00012D6D;
        ids = '{ID_RX_AVAIL, ID_TX_EMPTY, ID_LINE_ERR, ID_MODEM};
        fail_count = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        settle(3);
        wr(OFS_LINE_CTRL, 8'h80);
        `CHK("latch access", 1'b1, dla)
        rd(OFS_DATA_DIV_LOW);
        `CHK("div low reset", DIV_LOW_RESET, d)
        rd(OFS_IER_DIV_HIGH);
        `CHK("div high reset", DIV_HIGH_RESET, d)
        for (i = 0; i < 4; i++) begin
            r = xorshift(r);
            wr(OFS_DATA_DIV_LOW, r[7:0]);
            wr(OFS_IER_DIV_HIGH, r[15:8]);
            // high read right after its write keeps the readback check live
            rd(OFS_IER_DIV_HIGH);
            `CHK("div high", r[15:8], d)
            rd(OFS_DATA_DIV_LOW);
            `CHK("div low", r[7:0], d)
        end
        wr(OFS_LINE_CTRL, 8'h00);
        rd(OFS_DATA_DIV_LOW);
        `CHK("data read latch clear", READ_EMPTY, d)
        for (i = 0; i < 4; i++) begin
            r = xorshift(r);
            wr(OFS_IER_DIV_HIGH, r[7:0]);
            rd(OFS_IER_DIV_HIGH);
            `CHK("irq enables", {4'h0, r[3:0]}, d)
        end
        // line, data, empty and modem sources pending (timeout not); one enable at a time picks which one is seen
        @(posedge clk);
        {line_err, rx_data, tx_empty} <= 3'h7;
        modem_flip <= 4'h5;
        @(posedge clk);
        modem_flip <= 4'h0;
        for (i = 0; i < 4; i++) begin
            wr(OFS_IER_DIV_HIGH, 8'h01 << i);
            settle(3);
            `CHK("irq one enable", 1'b1, irq)
            rd(OFS_FCR_IIR);
            `CHK("ident one enable", {4'h0, ids[i]}, d)
        end
        wr(OFS_IER_DIV_HIGH, 8'h0F);
        rd(OFS_FCR_IIR);
        `CHK("ident priority", {4'h0, ID_LINE_ERR}, d)
        wr(OFS_IER_DIV_HIGH, 8'h00);
        settle(3);
        `CHK("irq all off", 1'b0, irq)
        rd(OFS_FCR_IIR);
        `CHK("ident all off", {4'h0, ID_NONE}, d)
        wr(OFS_IER_DIV_HIGH, 8'h08);
        @(posedge clk);
        {line_err, rx_data, tx_empty} <= 3'h0;
        modem_read <= 1'b1;
        @(posedge clk);
        modem_read <= 1'b0;
        settle(3);
        `CHK("modem irq cleared", 1'b0, irq)
        @(posedge clk);
        modem_flip <= 4'h2;
        @(posedge clk);
        modem_flip <= 4'h0;
        settle(3);
        `CHK("modem irq raised", 1'b1, irq)
        rd(OFS_FCR_IIR);
        `CHK("modem ident", {4'h0, ID_MODEM}, d)
        for (i = 0; i < 4; i++) begin
            wr(OFS_FCR_IIR, {i[1:0], 6'h01});
            `CHK("threshold", lvl(i[1:0]), rx_threshold)
            `CHK("queues on", 1'b1, queues_on)
            `CHK("no tx flush", 1'b0, txf)
        end
        wr(OFS_FCR_IIR, 8'h07);
        `CHK("tx flush", 1'b1, txf)
        `CHK("rx flush", 1'b1, rxf)
        settle(1);
        `CHK("rx flush clears", 1'b0, rxf)
        wr(OFS_FCR_IIR, 8'h09);
        `CHK("dma bit inert", 1'b0, rxf)
        wr(OFS_IER_DIV_HIGH, 8'h01);
        @(posedge clk);
        rx_to <= 1'b1;
        settle(3);
        rd(OFS_FCR_IIR);
        `CHK("timeout ident", {4'hC, ID_TIMEOUT}, d)
        // bit 0 clear: the level bits of this write must not land
        wr(OFS_FCR_IIR, 8'h46);
        `CHK("queues off", 1'b0, queues_on)
        `CHK("leave tx flush", 1'b1, txf)
        `CHK("leave rx flush", 1'b1, rxf)
        `CHK("level kept", lvl(2'h0), rx_threshold)
        wr(OFS_FCR_IIR, 8'h08);
        `CHK("dma bit off", 1'b0, queues_on | txf | rxf)
        @(posedge clk);
        rx_to <= 1'b0;
        for (i = 0; i < 5; i++) begin
            dv = (i == 4) ? 0 : ((i == 3) ? 1 : 2);
            wr(OFS_LINE_CTRL, 8'h80);
            wr(OFS_DATA_DIV_LOW, dv[7:0]);
            wr(OFS_IER_DIV_HIGH, {i[0], 7'h00});
            wr(OFS_LINE_CTRL, 8'h00);
            @(posedge clk);
            ext_choice <= i[1];
            settle(4);
            cnt = 0;
            repeat (240) begin
                @(posedge clk);
                #1;
                if (baud16 === 1'b1) cnt++;
            end
            per = i[1] ? 3 : (i[0] ? 2 : 5);
            exp_n = (dv == 0) ? 0 : 240 / (per * dv);
            `CHK("baud pulses", 1'b1, (cnt >= exp_n - 1 && cnt <= exp_n + 1))
        end
        end_of_test();
    end
endmodule
